// File: verilog/oscsel_top.sv
// oscillator source select: mode decode, start-up counter, pin control
// assumes osc_pin_in_i and pll_lock_i are synchronous to sys_clk_i
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module oscsel_top
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [oscsel_pkg::CFG_W-1:0] nv_config_i,
  input wire logic nv_valid_i,
  input wire logic osc_pin_in_i,
  input wire logic pll_lock_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic clk_release_o,
  output logic [2:0] mode_o,
  output logic pll_en_o,
  output logic fast_periph_ok_o,
  output logic osc_pin_out_o,
  output logic osc_pin_out_oe_n_o,
  output logic feedback_en_o,
  output logic irq_o
);
  import oscsel_pkg::*;

  logic [CFG_W-1:0] cfg_reg;
  oscsel_state_t state_reg;
  logic [STARTUP_W-1:0] cnt_reg;
  logic pin_prev_reg;
  logic lock_reg;
  logic sleep_reg;
  logic div2_reg;
  logic [EV_W-1:0] irq_stat_reg;
  logic [EV_W-1:0] irq_mask_reg;
  oscsel_mode_t mode_next;
  logic [1:0] grp;
  logic [1:0] pmode;
  logic osc_edge;
  logic is_pll;
  logic is_ext;
  logic [EV_W-1:0] events;

  // mode decode from group and primary mode
  function automatic oscsel_mode_t decode_mode(input logic [1:0] g, input logic [1:0] p);
    case (g)
      GRP_PRI_PLL: decode_mode = (p == PM_XTAL) ? OSCSEL_XTAL_PLL : OSCSEL_EXT_PLL;
      GRP_RC_PLL: decode_mode = OSCSEL_RC_PLL;
      GRP_PRI: decode_mode = (p == PM_XTAL) ? OSCSEL_XTAL : OSCSEL_EXT;
      default: decode_mode = OSCSEL_RC;
    endcase
  endfunction

  assign grp = cfg_reg[POS_GROUP +: 2];
  assign pmode = cfg_reg[POS_PMODE +: 2];
  assign mode_next = decode_mode(grp, pmode);
  assign is_pll = (mode_next == OSCSEL_RC_PLL) || (mode_next == OSCSEL_EXT_PLL) ||
                  (mode_next == OSCSEL_XTAL_PLL);
  assign is_ext = (mode_next == OSCSEL_EXT) || (mode_next == OSCSEL_EXT_PLL);
  assign osc_edge = osc_pin_in_i & ~pin_prev_reg;

  // configuration latch while the start-up state waits for storage
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg <= CFG_RESET;
    end else if (state_reg == OSCSEL_ST_CFG && nv_valid_i) begin
      cfg_reg <= nv_config_i;
    end
  end

  // oscillator edge tracker for counting periods
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= osc_pin_in_i;
    end
  end

  // start-up sequencing: config, wait, run, sleep
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= OSCSEL_ST_CFG;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        OSCSEL_ST_CFG: begin
          cnt_reg <= '0;
          if (nv_valid_i) begin
            state_reg <= OSCSEL_ST_WAIT;
          end
        end
        OSCSEL_ST_WAIT: begin
          if (mode_next != OSCSEL_XTAL && mode_next != OSCSEL_XTAL_PLL) begin
            state_reg <= OSCSEL_ST_RUN;
          end else if (osc_edge) begin
            if (cnt_reg == STARTUP_LAST) begin
              state_reg <= OSCSEL_ST_RUN;
            end
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        OSCSEL_ST_RUN: begin
          if (sleep_reg) begin
            state_reg <= OSCSEL_ST_SLEEP;
          end
        end
        OSCSEL_ST_SLEEP: begin
          cnt_reg <= '0;
          if (!sleep_reg) begin
            state_reg <= OSCSEL_ST_WAIT;
          end
        end
        default: state_reg <= OSCSEL_ST_CFG;
      endcase
    end
  end

  // lock mirror, only meaningful with the x32 multiplier on
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= pll_lock_i & is_pll & (state_reg != OSCSEL_ST_CFG);
    end
  end

  // clock output divider for pin two
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div2_reg <= 1'b0;
    end else if (state_reg == OSCSEL_ST_RUN) begin
      div2_reg <= ~div2_reg;
    end else begin
      div2_reg <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_release_o <= 1'b0;
      mode_o <= 3'h0;
      pll_en_o <= 1'b0;
      fast_periph_ok_o <= 1'b0;
      osc_pin_out_o <= 1'b0;
      osc_pin_out_oe_n_o <= 1'b1;
      feedback_en_o <= 1'b0;
    end else begin
      clk_release_o <= (state_reg == OSCSEL_ST_RUN);
      mode_o <= mode_next;
      pll_en_o <= is_pll & (state_reg != OSCSEL_ST_CFG); // gain fixed x32
      fast_periph_ok_o <= is_pll & lock_reg;
      osc_pin_out_o <= div2_reg;
      // pin two drives clock only when selected, crystal modes use it for the crystal
      osc_pin_out_oe_n_o <= ~(cfg_reg[POS_CLOCK_OUTPUT] && state_reg == OSCSEL_ST_RUN &&
                              (mode_next != OSCSEL_XTAL) &&
                              (mode_next != OSCSEL_XTAL_PLL));
      // feedback only for crystal; off in external clock modes
      feedback_en_o <= ~is_ext && (pmode == PM_XTAL) && (grp[1] == 1'b1) &&
                       (state_reg != OSCSEL_ST_SLEEP);
    end
  end

  // software sleep request
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleep_reg <= 1'b0;
    end else if (wr_i && addr_i == ADDR_CONTROL) begin
      sleep_reg <= wdata_i[POS_SLEEP];
    end
  end

  // interrupt events: release, lock gain, lock loss
  assign events[EV_READY] = (state_reg == OSCSEL_ST_WAIT) &&
                            ((mode_next != OSCSEL_XTAL && mode_next != OSCSEL_XTAL_PLL) ||
                             (osc_edge && cnt_reg == STARTUP_LAST));
  assign events[EV_LOCK_GAIN] = pll_lock_i & is_pll & (state_reg != OSCSEL_ST_CFG) & ~lock_reg;
  assign events[EV_LOCK_LOSS] = ~(pll_lock_i & is_pll & (state_reg != OSCSEL_ST_CFG)) & lock_reg;

  // sticky status, cleared by read, set wins over clear
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat_reg <= '0;
    end else if (rd_i && addr_i == ADDR_IRQ_STAT) begin
      irq_stat_reg <= events;
    end else begin
      irq_stat_reg <= irq_stat_reg | events;
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_mask_reg <= '0;
    end else if (wr_i && addr_i == ADDR_IRQ_MASK) begin
      irq_mask_reg <= wdata_i[EV_W-1:0];
    end
  end

  // interrupt output, registered
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_stat_reg | events) & ~((rd_i && addr_i == ADDR_IRQ_STAT) ?
               irq_stat_reg & ~events : '0)) & irq_mask_reg);
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CONFIG: rdata_o <= {8'h00, cfg_reg}; // writes ignored
        ADDR_CONTROL: rdata_o <= {21'h0, mode_next, 3'h0,
                                  ~fast_periph_ok_o,
                                  cfg_reg[POS_SWMON + 1], // switching disabled
                                  clk_release_o, lock_reg, sleep_reg};
        ADDR_IRQ_STAT: rdata_o <= {29'h0, irq_stat_reg};
        ADDR_IRQ_MASK: rdata_o <= {29'h0, irq_mask_reg};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  // assertions
  property p_lock_follows;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (!pll_lock_i) |=> !lock_reg;
  endproperty
  a_lock_follows: assert property (p_lock_follows)
    else $error("lock flag kept after loss");

  property p_rc_no_wait;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg == OSCSEL_ST_WAIT && mode_next == OSCSEL_RC) |=> state_reg == OSCSEL_ST_RUN;
  endproperty
  a_rc_no_wait: assert property (p_rc_no_wait)
    else $error("rc mode delayed");

  property p_release_late;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg == OSCSEL_ST_WAIT && mode_next == OSCSEL_XTAL && cnt_reg != STARTUP_LAST)
        |=> state_reg != OSCSEL_ST_RUN;
  endproperty
  a_release_late: assert property (p_release_late)
    else $error("crystal released early");

  property p_wake_waits;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg == OSCSEL_ST_SLEEP && !sleep_reg) |=> state_reg == OSCSEL_ST_WAIT && cnt_reg == 0;
  endproperty
  a_wake_waits: assert property (p_wake_waits)
    else $error("wake skipped start-up");

  property p_cfg_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg != OSCSEL_ST_CFG) |=> $stable(cfg_reg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config changed after latch");

  property p_fast_needs_pll;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      fast_periph_ok_o |-> pll_en_o;
  endproperty
  a_fast_needs_pll: assert property (p_fast_needs_pll)
    else $error("fast periph without pll");

  property p_div2;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg == OSCSEL_ST_RUN) [*3] |-> osc_pin_out_o != $past(osc_pin_out_o);
  endproperty
  a_div2: assert property (p_div2)
    else $error("clock output not toggling");

  property p_decode;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (grp == GRP_RC_PLL) |=> mode_o == OSCSEL_RC_PLL;
  endproperty
  a_decode: assert property (p_decode)
    else $error("group decode wrong");

  // crystal start-up: the last counted edge ends the wait
  sequence s_xtal_last_edge;
    state_reg == OSCSEL_ST_WAIT && osc_edge && cnt_reg == STARTUP_LAST &&
      (mode_next == OSCSEL_XTAL || mode_next == OSCSEL_XTAL_PLL);
  endsequence

  property p_xtal_release;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_xtal_last_edge |=> state_reg == OSCSEL_ST_RUN ##1 clk_release_o;
  endproperty
  a_xtal_release: assert property (p_xtal_release)
    else $error("crystal not released after last start-up edge");

  // sleep entry: running with a request, then the sleep state
  sequence s_sleep_entry;
    (state_reg == OSCSEL_ST_RUN && sleep_reg) ##1 (state_reg == OSCSEL_ST_SLEEP);
  endsequence

  property p_sleep_holds_clock;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_sleep_entry |=> !clk_release_o;
  endproperty
  a_sleep_holds_clock: assert property (p_sleep_holds_clock)
    else $error("clock still released in sleep");

  property p_lock_gain;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (pll_lock_i && is_pll && state_reg != OSCSEL_ST_CFG) |=> lock_reg;
  endproperty
  a_lock_gain: assert property (p_lock_gain)
    else $error("lock flag missed");

  property p_clock_output_off;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !cfg_reg[POS_CLOCK_OUTPUT] |=> osc_pin_out_oe_n_o;
  endproperty
  a_clock_output_off: assert property (p_clock_output_off)
    else $error("pin two driven without clock-out select");

  property p_ext_no_feedback;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      is_ext |=> !feedback_en_o;
  endproperty
  a_ext_no_feedback: assert property (p_ext_no_feedback)
    else $error("feedback on with external clock");
endmodule

// File: verilog/oscsel_pkg.sv
// oscillator source select: shared constants, register map, mode types
// assumes a single 40 MHz system clock and a simple strobe register port
package oscsel_pkg;
  // system clock
  localparam int CLK_PERIOD_NS = 25;
  // register map (word addresses on the plain port)
  localparam logic [3:0] ADDR_CONFIG = 4'h0; // latched configuration word
  localparam logic [3:0] ADDR_CONTROL = 4'h1; // sleep request, status
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2; // sticky events, clear on read
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  // configuration word fields
  localparam int CFG_W = 24;
  localparam int POS_PMODE = 0; // primary osc mode, 2 bits
  localparam int POS_CLOCK_OUTPUT = 2; // pin two clock output enable
  localparam int POS_RANGE = 5; // internal rc range
  localparam int POS_SWMON = 6; // switch and monitor select, 2 bits
  localparam int POS_GROUP = 8; // initial source group, 2 bits
  localparam logic [CFG_W-1:0] CFG_RESET = 24'h0000C3;
  // control/status fields
  localparam int POS_SLEEP = 0;
  localparam int POS_LOCK = 1;
  localparam int POS_READY = 2;
  localparam int POS_SWDIS = 3;
  localparam int POS_NOFAST = 4;
  localparam int POS_MODE = 8; // 3 bits
  // interrupt event bits
  localparam int EV_READY = 0;
  localparam int EV_LOCK_GAIN = 1;
  localparam int EV_LOCK_LOSS = 2;
  localparam int EV_W = 3;
  // group and primary mode codes
  localparam logic [1:0] GRP_RC = 2'h0;
  localparam logic [1:0] GRP_RC_PLL = 2'h1;
  localparam logic [1:0] GRP_PRI = 2'h2;
  localparam logic [1:0] GRP_PRI_PLL = 2'h3;
  localparam logic [1:0] PM_EXT = 2'h0;
  localparam logic [1:0] PM_XTAL = 2'h2;
  // start-up counter and multiplier
  localparam int STARTUP_W = 10;
  localparam logic [STARTUP_W-1:0] STARTUP_LAST = 10'h3FF; // 1024 periods
  localparam int PLL_GAIN = 32;
  typedef enum logic [2:0] {
    OSCSEL_RC, OSCSEL_RC_PLL, OSCSEL_EXT, OSCSEL_XTAL,
    OSCSEL_EXT_PLL, OSCSEL_XTAL_PLL
  } oscsel_mode_t;
  typedef enum logic [1:0] {OSCSEL_ST_CFG, OSCSEL_ST_WAIT, OSCSEL_ST_RUN, OSCSEL_ST_SLEEP}
    oscsel_state_t;
endpackage

// File: testbench/oscsel_osc_model.sv
// oscillator source model: a crystal or external clock on pin one
// assumes the source is synchronous to the system clock, as the block expects
`timescale 1ns/1ps
module oscsel_osc_model #(
  parameter int HALF = 2
) (
  input wire logic sys_clk_i,
  input wire logic run_i,
  output logic osc_o
);
  int cnt = 0;
  logic lvl = 1'b0;
  assign osc_o = lvl;
  // toggle every HALF cycles while running; a stopped source stands still at low
  always @(posedge sys_clk_i) begin
    if (!run_i) begin
      lvl <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      lvl <= ~lvl;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: testbench/tb_oscillator_source_select.sv
// testbench for the oscillator source select: every group and mode, start-up, sleep, irq
// assumes oscsel_top and the oscillator source model are compiled before it
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_oscillator_source_select;
  import oscsel_pkg::*;
  logic sys_clk_i, nrst_i, nv_valid_i, pll_lock_i, wr_i, rd_i, osc_run, osc_pin_in;
  logic rd_d = 1'b0; // only the read monitor drives it
  logic clk_release_o, pll_en_o, fast_periph_ok_o, osc_pin_out_o, osc_pin_out_oe_n_o;
  logic feedback_en_o, irq_o, pll, xt, p0;
  logic [CFG_W-1:0] nv_config_i, cfg;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [2:0] mode_o, md;
  logic [31:0] exp_q[$], msk_q[$];
  logic [9:0] tab [8] = '{10'h003, 10'h007, 10'h107, 10'h204, 10'h200, 10'h300, 10'h206, 10'h302};
  logic [2:0] mtab [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h4, 3'h3, 3'h5};
  int errors, tests_run, seed, i, n;
  oscsel_top DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .nv_config_i(nv_config_i),
    .nv_valid_i(nv_valid_i), .osc_pin_in_i(osc_pin_in), .pll_lock_i(pll_lock_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .clk_release_o(clk_release_o),
    .mode_o(mode_o), .pll_en_o(pll_en_o), .fast_periph_ok_o(fast_periph_ok_o),
    .osc_pin_out_o(osc_pin_out_o), .osc_pin_out_oe_n_o(osc_pin_out_oe_n_o),
    .feedback_en_o(feedback_en_o), .irq_o(irq_o));
  oscsel_osc_model #(.HALF(2)) osc (.sys_clk_i(sys_clk_i), .run_i(osc_run), .osc_o(osc_pin_in));
  // system clock
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic wait_rel(input int lim);
    n = 0;
    while (clk_release_o !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic test_done;
    repeat (3) @(posedge sys_clk_i);
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // read data monitor: oldest note against the word in the cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (rd_d === 1'b1) begin
      `CHK("rdata", exp_q[0], rdata_o & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_d <= rd_i;
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    errors++;
    test_done();
  end
  // main sequence: one power-on per table entry
  initial begin
    seed = 48121;
    errors = 0;
    tests_run = 0;
    {nrst_i, nv_valid_i, pll_lock_i, wr_i, rd_i, osc_run} = '0;
    nv_config_i = '0;
    addr_i = '0;
    wdata_i = '0;
    for (i = 0; i < 8; i++) begin
      cfg = {14'h0, tab[i]} | (24'($random(seed)) & 24'h0000E0);
      md = mtab[i];
      pll = (md == 3'h1 || md == 3'h4 || md == 3'h5);
      xt = (md == 3'h3 || md == 3'h5);
      nrst_i <= 1'b0;
      nv_valid_i <= 1'b0;
      osc_run <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      nv_valid_i <= 1'b1;
      nv_config_i <= cfg;
      osc_run <= xt;
      repeat (2) @(posedge sys_clk_i);
      nv_config_i <= ~cfg;
      if (xt) begin
        repeat (1000) @(posedge osc_pin_in);
        #1;
        `CHK("early", 1'b0, clk_release_o)
      end
      wait_rel(xt ? 300 : 20);
      `CHK("release", 1'b1, clk_release_o)
      `CHK("mode", md, mode_o)
      `CHK("pll_en", pll, pll_en_o)
      `CHK("oe_n", !(cfg[2] && !xt), osc_pin_out_oe_n_o)
      if (md == 3'h2 && !cfg[2]) `CHK("feedback", 1'b0, feedback_en_o)
      if (xt) `CHK("feedback", 1'b1, feedback_en_o)
      if (osc_pin_out_oe_n_o === 1'b0) begin
        p0 = osc_pin_out_o;
        cyc(1);
        `CHK("clock_output", ~p0, osc_pin_out_o)
      end
      wr(ADDR_CONFIG, $random(seed));
      rd(ADDR_CONFIG, {8'h00, cfg}, 32'hFFFFFFFF);
      pll_lock_i <= 1'b1;
      cyc(3);
      `CHK("fast_ok", pll, fast_periph_ok_o)
      rd(ADDR_CONTROL, {21'h0, md, 3'h0, !pll, cfg[7], 1'b1, pll, 1'b0}, 32'h0000071F);
      pll_lock_i <= 1'b0;
      cyc(3);
      `CHK("fast_off", 1'b0, fast_periph_ok_o)
      wr(ADDR_IRQ_MASK, 32'h00000001);
      cyc(2);
      `CHK("irq_on", 1'b1, irq_o)
      rd(ADDR_IRQ_STAT, {29'h0, pll, pll, 1'b1}, 32'h00000007);
      cyc(2);
      `CHK("irq_off", 1'b0, irq_o)
      rd(ADDR_IRQ_STAT, 32'h00000000, 32'h00000007);
      wr(ADDR_IRQ_MASK, 32'h00000000);
      wr(ADDR_CONTROL, 32'h00000001);
      cyc(3);
      `CHK("sleep", 1'b0, clk_release_o)
      wr(ADDR_CONTROL, 32'h00000000);
      if (xt) begin
        repeat (500) @(posedge osc_pin_in);
        #1;
        `CHK("wake_early", 1'b0, clk_release_o)
      end
      wait_rel(xt ? 2400 : 20);
      `CHK("wake", 1'b1, clk_release_o)
      $display("case %0d done", i);
    end
    rd(4'hF, 32'h00000000, 32'hFFFFFFFF);
    test_done();
  end
endmodule
